// *** hw/e1_rx_status.sv ***
// module: e1 rx cas change flags and national bits, avalon-mm slave
// Summary of operation
// [R1] timeslots 8..15 change flags; bit 7 is timeslot 8, bit 0 timeslot 15
// [R2] timeslots 16..23 change flags; bit 7 is timeslot 16
// [R3] timeslots 24..31 change flags; bit 7 is timeslot 24
// [R4] flags reset to zero and clear when their register is read
// [R5] flags only update while cas is in use, otherwise stay zero
// [R6] bit 7 holds international bit of latest alignment frame
// [R7] bit 6 holds international bit of latest other frame
// [R8] bit 5 holds remote alarm, bit 3 of latest other frame
// [R9] bits 4..0 hold national bits four to eight of latest other frame
// [R10] cas counts as enabled only for select codes 001 and 011
// [R11] change in the read cycle leaves its flag set afterwards
// [R12] capture updates once per matching frame; writes are ignored
//
// The Avalon-MM register port was decided locally.
`default_nettype none
module e1_rx_status (
  input  wire logic        clk_i,             // framer clock, 125 MHz
  input  wire logic        reset_n_i,         // async reset, active low
  input  wire logic [15:0] avs_address_i,     // byte address
  input  wire logic        avs_read_i,        // read request
  input  wire logic        avs_write_i,       // write request
  input  wire logic [31:0] avs_writedata_i,   // write data
  input  wire logic [3:0]  avs_byteenable_i,  // byte lanes
  output logic      [31:0] avs_readdata_o,    // read data, registered
  output logic             avs_waitrequest_o, // stall request
  input  wire logic        cas_valid_i,       // cas nibble strobe
  input  wire logic [4:0]  cas_timeslot_i,    // timeslot of the nibble
  input  wire logic [3:0]  cas_data_i,        // abcd signaling bits
  input  wire logic        frame_valid_i,     // timeslot 0 byte strobe
  input  wire logic        frame_is_align_i,  // byte is from align frame
  input  wire logic [7:0]  ts0_byte_i,        // timeslot 0, bit 1 is msb
  output logic             irq_o              // level interrupt
);
  localparam int unsigned NS = e1_rx_status_pkg::CAS_SLOTS;
  localparam int unsigned GW = e1_rx_status_pkg::GROUP_W;
  localparam int unsigned IW = e1_rx_status_pkg::IRQ_W;

  e1_rx_status_pkg::bus_state_t state_ff;
  logic [13:0]   idx;
  logic          rd_accept;
  logic          wr_accept;
  logic [7:0]    rd_value;
  logic [31:0]   rdata_ff;
  logic [2:0]    sig_select_ff;
  logic          cas_en;
  logic [NS-1:0] flags_ff;
  logic [NS-1:0] nxt_flags;
  logic [NS-1:0] clr_vec;
  logic [NS-1:0] cas_set;
  logic [7:0]    nat_ff;
  logic [IW-1:0] status_ff;
  logic [IW-1:0] nxt_status;
  logic [IW-1:0] mask_ff;
  logic [IW-1:0] events;
  logic [IW-1:0] w1c;

  cas_chg_if cas_bus (.clk_i(clk_i), .reset_n_i(reset_n_i));

  // timeslot 8 sits in the top bit of its register, so groups reverse
  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction : rev8

  function automatic logic cas_selected(input logic [2:0] sel);
    return (sel == e1_rx_status_pkg::SEL_CAS_DL) ||
           (sel == e1_rx_status_pkg::SEL_CAS_ONES);
  endfunction : cas_selected

  // ---- avalon slave: one wait cycle, then the answer
  assign idx       = avs_address_i[15:2];
  assign rd_accept = (state_ff == e1_rx_status_pkg::BUS_ANSWER) &&
                     avs_read_i;
  assign wr_accept = (state_ff == e1_rx_status_pkg::BUS_ANSWER) &&
                     avs_write_i && avs_byteenable_i[0];
  assign avs_waitrequest_o = (state_ff == e1_rx_status_pkg::BUS_IDLE) &&
                             (avs_read_i || avs_write_i);
  assign avs_readdata_o    = rdata_ff;

  // request handshake; master holds the request through the answer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= e1_rx_status_pkg::BUS_IDLE;
    end else begin
      case (state_ff)
        e1_rx_status_pkg::BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            state_ff <= e1_rx_status_pkg::BUS_ANSWER;
          end
        end
        e1_rx_status_pkg::BUS_ANSWER: begin
          state_ff <= e1_rx_status_pkg::BUS_IDLE;
        end
        default: begin
          state_ff <= e1_rx_status_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // read mux; unmapped indices read as zero
  always_comb begin
    case (idx)
      e1_rx_status_pkg::IDX_SIG_SELECT: rd_value = {5'h00, sig_select_ff};
      e1_rx_status_pkg::IDX_FLAGS_TS8:  rd_value = rev8(flags_ff[7:0]);
      e1_rx_status_pkg::IDX_FLAGS_TS16: rd_value = rev8(flags_ff[15:8]);
      e1_rx_status_pkg::IDX_FLAGS_TS24: rd_value = rev8(flags_ff[23:16]);
      e1_rx_status_pkg::IDX_NATIONAL:   rd_value = nat_ff;
      e1_rx_status_pkg::IDX_IRQ_STATUS: rd_value = {6'h00, status_ff};
      e1_rx_status_pkg::IDX_IRQ_MASK:   rd_value = {6'h00, mask_ff};
      default:                          rd_value = 8'h00;
    endcase
  end

  // snapshot taken in the wait cycle; it is what the master receives
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_waitrequest_o && avs_read_i) begin
      rdata_ff <= {24'h00_0000, rd_value};
    end
  end

  // ---- writable control: signaling select and interrupt mask
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sig_select_ff <= e1_rx_status_pkg::SIG_SELECT_RST;
      mask_ff       <= e1_rx_status_pkg::IRQ_RST;
    end else if (wr_accept) begin
      if (idx == e1_rx_status_pkg::IDX_SIG_SELECT) begin
        sig_select_ff <= avs_writedata_i[2:0];
      end
      if (idx == e1_rx_status_pkg::IDX_IRQ_MASK) begin
        mask_ff <= avs_writedata_i[IW-1:0];
      end
    end
  end

  assign cas_en = cas_selected(sig_select_ff);  // [R10]

  // ---- change detection in the helper module
  assign cas_bus.valid    = cas_valid_i;
  assign cas_bus.timeslot = cas_timeslot_i;
  assign cas_bus.data     = cas_data_i;
  assign cas_bus.enable   = cas_en;  // [R5]
  assign cas_set          = cas_bus.set_mask;

  cas_change_detect u_detect (
    .bus (cas_bus.detect)
  );

  // only bits the master actually saw as set are cleared, so a change
  // landing between snapshot and answer survives the read
  always_comb begin
    clr_vec = '0;
    if (rd_accept) begin
      case (idx)
        e1_rx_status_pkg::IDX_FLAGS_TS8:
          clr_vec[7:0] = rev8(rdata_ff[7:0]);  // [R1]
        e1_rx_status_pkg::IDX_FLAGS_TS16:
          clr_vec[15:8] = rev8(rdata_ff[7:0]);  // [R2]
        e1_rx_status_pkg::IDX_FLAGS_TS24:
          clr_vec[23:16] = rev8(rdata_ff[7:0]);  // [R3]
        default:
          clr_vec = '0;
      endcase
    end
  end

  // set wins over the read clear; flags drop while cas is off
  always_comb begin
    if (cas_en) begin
      nxt_flags = (flags_ff & ~clr_vec) | cas_set;  // [R11]
    end else begin
      nxt_flags = '0;  // [R5]
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_ff <= {3{e1_rx_status_pkg::FLAGS_RST}};  // [R4]
    end else begin
      flags_ff <= nxt_flags;  // [R4]
    end
  end

  // ---- timeslot 0 capture; register is read only, writes fall away
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nat_ff <= e1_rx_status_pkg::NATIONAL_RST;
    end else if (frame_valid_i) begin  // [R12]
      if (frame_is_align_i) begin
        nat_ff[e1_rx_status_pkg::NAT_SI_ALIGN_POS] <=
          ts0_byte_i[e1_rx_status_pkg::TS0_SI_POS];  // [R6]
      end else begin
        // bit 2 of the other frame is fixed high and is not kept
        nat_ff[6:0] <= {
          ts0_byte_i[e1_rx_status_pkg::TS0_SI_POS],        // [R7]
          ts0_byte_i[e1_rx_status_pkg::TS0_ALARM_POS],     // [R8]
          ts0_byte_i[e1_rx_status_pkg::TS0_ALARM_POS-1:0]  // [R9]
        };
      end
    end
  end

  // ---- interrupts: sticky events, write one to clear, set wins
  always_comb begin
    events = '0;
    events[e1_rx_status_pkg::IRQ_CAS_POS] = |cas_set;
    events[e1_rx_status_pkg::IRQ_NAT_POS] = frame_valid_i &&
      !frame_is_align_i &&
      (nat_ff[5:0] != ts0_byte_i[e1_rx_status_pkg::TS0_ALARM_POS:0]);
    w1c = '0;
    if (wr_accept && (idx == e1_rx_status_pkg::IDX_IRQ_STATUS)) begin
      w1c = avs_writedata_i[IW-1:0];
    end
    nxt_status = (status_ff & ~w1c) | events;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_ff <= e1_rx_status_pkg::IRQ_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  assign irq_o = |(status_ff & mask_ff);

  // ---- checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_request;
    (state_ff == e1_rx_status_pkg::BUS_IDLE) && (avs_read_i || avs_write_i);
  endsequence
  sequence s_read_ts8;
    (avs_waitrequest_o && avs_read_i &&
     (idx == e1_rx_status_pkg::IDX_FLAGS_TS8))
    ##1 rd_accept ##0 (cas_set[7:0] == '0);
  endsequence
  sequence s_read_walk;
    ((state_ff == e1_rx_status_pkg::BUS_IDLE) && avs_read_i)
    ##1 ((state_ff == e1_rx_status_pkg::BUS_ANSWER) && avs_read_i);
  endsequence

  a_bus_one_wait:
    assert property (s_request |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("answer not given after one wait cycle");

  a_set_low_group:  // [R1]
    assert property (cas_en && |cas_set[7:0]
                     |=> ((flags_ff[7:0] & $past(cas_set[7:0])) ==
                          $past(cas_set[7:0])))
    else $error("timeslot 8..15 change not flagged");

  a_ts16_bit_order:  // [R2]
    assert property ((idx == e1_rx_status_pkg::IDX_FLAGS_TS16)
                     |-> (rd_value[7] == flags_ff[8]) &&
                         (rd_value[0] == flags_ff[15]))
    else $error("timeslot 16..23 bit order wrong");

  a_set_high_group:  // [R3]
    assert property (cas_en && |cas_set[23:16]
                     |=> ((flags_ff[23:16] & $past(cas_set[23:16])) ==
                          $past(cas_set[23:16])))
    else $error("timeslot 24..31 change not flagged");

  a_read_clears:  // [R4]
    assert property (s_read_ts8 |=>
                     ((flags_ff[7:0] & rev8($past(rdata_ff[7:0]))) == '0))
    else $error("read did not clear the flags it returned");

  a_flags_off:  // [R5]
    assert property (!cas_en |=> (flags_ff == '0))
    else $error("flags held while cas disabled");

  a_select_gate:  // [R10]
    assert property (!cas_selected(sig_select_ff) |-> (cas_set == '0))
    else $error("change pulse under non-cas select code");

  a_align_capture:  // [R6]
    assert property (frame_valid_i && frame_is_align_i
                     |=> (nat_ff[7] == $past(ts0_byte_i[7])) &&
                         $stable(nat_ff[6:0]))
    else $error("align frame international bit not captured");

  a_other_si:  // [R7]
    assert property (frame_valid_i && !frame_is_align_i
                     |=> (nat_ff[6] == $past(ts0_byte_i[7])) &&
                         $stable(nat_ff[7]))
    else $error("other frame international bit not captured");

  a_alarm_capture:  // [R8]
    assert property (frame_valid_i && !frame_is_align_i
                     |=> nat_ff[5] == $past(ts0_byte_i[5]))
    else $error("remote alarm bit not captured");

  a_national_capture:  // [R9]
    assert property (frame_valid_i && !frame_is_align_i
                     |=> nat_ff[4:0] == $past(ts0_byte_i[4:0]))
    else $error("national bits not captured");

  a_set_beats_read:  // [R11]
    assert property (rd_accept && cas_en && |cas_set
                     |=> ((flags_ff & $past(cas_set)) == $past(cas_set)))
    else $error("change lost under a read");

  a_capture_ro:  // [R12]
    assert property (!frame_valid_i |=> $stable(nat_ff))
    else $error("capture changed without a frame");

  a_ts8_bit_order:  // [R1]
    assert property ((idx == e1_rx_status_pkg::IDX_FLAGS_TS8)
                     |-> (rd_value[7] == flags_ff[0]) &&
                         (rd_value[0] == flags_ff[7]))
    else $error("timeslot 8..15 bit order wrong");

  a_ts24_bit_order:  // [R3]
    assert property ((idx == e1_rx_status_pkg::IDX_FLAGS_TS24)
                     |-> (rd_value[7] == flags_ff[16]) &&
                         (rd_value[0] == flags_ff[23]))
    else $error("timeslot 24..31 bit order wrong");

  // slots below the first tracked one carry framing, never signaling
  a_low_slots_quiet:  // [R1]
    assert property (cas_valid_i &&
                     (cas_timeslot_i < e1_rx_status_pkg::FIRST_CAS_TS)
                     |-> (cas_set == '0))
    else $error("change pulse for an untracked timeslot");

  a_select_write:  // [R10]
    assert property (wr_accept && (idx == e1_rx_status_pkg::IDX_SIG_SELECT)
                     |=> (sig_select_ff == $past(avs_writedata_i[2:0])))
    else $error("signaling select write did not land");

  // the answer must carry what the wait cycle saw, not the live value
  a_read_snapshot:
    assert property (s_read_walk
                     |-> (avs_readdata_o == {24'h00_0000, $past(rd_value)}))
    else $error("read data is not the snapshot of the wait cycle");

  a_event_beats_clear:
    assert property ((events != '0)
                     |=> ((status_ff & $past(events)) == $past(events)))
    else $error("interrupt event lost under a clear");

  a_status_sticky:
    assert property ((w1c == '0)
                     |=> ((status_ff & $past(status_ff)) == $past(status_ff)))
    else $error("interrupt status dropped without a clear");
endmodule : e1_rx_status
`default_nettype wire

// *** hw/e1_rx_status_pkg.sv ***
// package: register map, field positions and states of the e1 rx status block
`default_nettype none
package e1_rx_status_pkg;
  // register indices; byte address is four times the index
  localparam int unsigned IDX_W         = 14;
  localparam logic [13:0] IDX_SIG_SELECT = 14'h010C;
  localparam logic [13:0] IDX_FLAGS_TS8  = 14'h010E;
  localparam logic [13:0] IDX_FLAGS_TS16 = 14'h010F;
  localparam logic [13:0] IDX_FLAGS_TS24 = 14'h0110;
  localparam logic [13:0] IDX_NATIONAL   = 14'h0111;
  localparam logic [13:0] IDX_IRQ_STATUS = 14'h0120;
  localparam logic [13:0] IDX_IRQ_MASK   = 14'h0121;
  // reset values
  localparam logic [2:0]  SIG_SELECT_RST = 3'h0;
  localparam logic [7:0]  FLAGS_RST      = 8'h00;
  localparam logic [7:0]  NATIONAL_RST   = 8'h00;
  localparam logic [1:0]  IRQ_RST        = 2'h0;
  // signaling select codes that turn channel-associated signaling on
  localparam logic [2:0]  SEL_CAS_DL     = 3'h1;
  localparam logic [2:0]  SEL_CAS_ONES   = 3'h3;
  // field positions
  localparam int unsigned IRQ_W            = 2;
  localparam int unsigned IRQ_CAS_POS      = 0;
  localparam int unsigned IRQ_NAT_POS      = 1;
  localparam int unsigned NAT_SI_ALIGN_POS = 7;
  localparam int unsigned TS0_SI_POS       = 7;
  localparam int unsigned TS0_ALARM_POS    = 5;
  // timeslot layout of the change flags
  localparam logic [4:0]  FIRST_CAS_TS   = 5'h08;
  localparam int unsigned CAS_SLOTS      = 24;
  localparam int unsigned CAS_W          = 4;
  localparam int unsigned GROUP_W        = 8;
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h1,
    BUS_ANSWER = 2'h2
  } bus_state_t;
endpackage : e1_rx_status_pkg
`default_nettype wire

// *** hw/cas_chg_if.sv ***
// interface: cas samples in, per-timeslot change pulses out
`default_nettype none
interface cas_chg_if (
  input wire logic clk_i,     // framer clock
  input wire logic reset_n_i  // async reset, active low
);
  logic                                   valid;
  logic [4:0]                             timeslot;
  logic [e1_rx_status_pkg::CAS_W-1:0]     data;
  logic                                   enable;
  logic [e1_rx_status_pkg::CAS_SLOTS-1:0] set_mask;
  modport source (input clk_i, reset_n_i, set_mask,
                  output valid, timeslot, data, enable);
  modport detect (input clk_i, reset_n_i, valid, timeslot, data, enable,
                  output set_mask);
endinterface : cas_chg_if
`default_nettype wire

// *** hw/cas_change_detect.sv ***
// module: keeps last cas nibble per timeslot and flags differences
`default_nettype none
module cas_change_detect (
  cas_chg_if.detect bus  // samples in, change pulses out
);
  logic [e1_rx_status_pkg::CAS_W-1:0] hist_ff [e1_rx_status_pkg::CAS_SLOTS];
  logic [4:0]                         slot;
  logic                               in_range;

  default clocking cb @(posedge bus.clk_i); endclocking
  default disable iff (!bus.reset_n_i);

  // timeslots below the first cas slot carry no tracked signaling
  always_comb begin
    in_range = (bus.timeslot >= e1_rx_status_pkg::FIRST_CAS_TS);
    slot     = bus.timeslot - e1_rx_status_pkg::FIRST_CAS_TS;
  end

  // history follows the line even while disabled, so re-enabling
  // does not report stale differences as changes
  always_ff @(posedge bus.clk_i or negedge bus.reset_n_i) begin
    if (!bus.reset_n_i) begin
      for (int i = 0; i < e1_rx_status_pkg::CAS_SLOTS; i++) begin
        hist_ff[i] <= '0;
      end
    end else if (bus.valid && in_range) begin
      hist_ff[slot] <= bus.data;
    end
  end

  // one pulse on the slot whose nibble differs from its history
  always_comb begin
    bus.set_mask = '0;
    if (bus.valid && in_range && bus.enable &&
        (bus.data != hist_ff[slot])) begin
      bus.set_mask[slot] = 1'b1;  // [R1]
    end
  end

  a_change_pulses:  // [R2]
    assert property (bus.valid && in_range && bus.enable &&
                     (bus.data != hist_ff[slot])
                     |-> $onehot(bus.set_mask))
    else $error("cas change did not raise exactly one pulse");

  a_disabled_quiet:  // [R5]
    assert property (!bus.enable |-> (bus.set_mask == '0))
    else $error("change pulse while cas disabled");
endmodule : cas_change_detect
`default_nettype wire

// *** dv/framer_feed_model.sv ***
// framer receive datapath model: feeds cas nibbles and timeslot 0 bytes
`default_nettype none
module framer_feed_model (
  input  wire logic       clk_i,         // framer clock
  output var  logic       cas_valid_o,   // cas nibble strobe
  output var  logic [4:0] cas_ts_o,      // timeslot of the nibble
  output var  logic [3:0] cas_data_o,    // abcd bits
  output var  logic       frame_valid_o, // timeslot 0 byte strobe
  output var  logic       frame_align_o, // byte from alignment frame
  output var  logic [7:0] ts0_byte_o     // timeslot 0 byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet datapath at time zero
  initial begin
    cas_valid_o   = 1'b0;
    cas_ts_o      = 5'h00;
    cas_data_o    = 4'h0;
    frame_valid_o = 1'b0;
    frame_align_o = 1'b0;
    ts0_byte_o    = 8'h00;
  end

  // one-cycle strobe; qualifiers inverted after it so no stale value helps
  task automatic send_cas(input logic [4:0] ts, input logic [3:0] d);
    @(posedge clk_i);
    cas_valid_o <= 1'b1;
    cas_ts_o    <= ts;
    cas_data_o  <= d;
    @(posedge clk_i);
    cas_valid_o <= 1'b0;
    cas_ts_o    <= ~ts;
    cas_data_o  <= ~d;
  endtask : send_cas

  // one timeslot 0 byte of either frame type
  task automatic send_frame(input logic align, input logic [7:0] b);
    @(posedge clk_i);
    frame_valid_o <= 1'b1;
    frame_align_o <= align;
    ts0_byte_o    <= b;
    @(posedge clk_i);
    frame_valid_o <= 1'b0;
    frame_align_o <= ~align;
    ts0_byte_o    <= ~b;
  endtask : send_frame
endmodule : framer_feed_model
`default_nettype wire

// *** dv/e1_rx_cas_change_and_national_bits_test.sv ***
// testbench: register bank, change flags, capture and interrupt
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  bad_count++; $display("unexpected at %0t: got %h want %h", $time, \
  (got), (exp)); end end
module e1_rx_cas_change_and_national_bits_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [15:0] avs_address_i = 16'h0000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [3:0]  avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        cas_valid_i, frame_valid_i, frame_is_align_i, irq_o;
  logic [4:0]  cas_timeslot_i;
  logic [3:0]  cas_data_i;
  logic [7:0]  ts0_byte_i;
  logic [31:0] rd;
  int          bad_count = 0;
  int          checks = 0;

  always #4 clk_i = ~clk_i;

  e1_rx_status i_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .cas_valid_i(cas_valid_i), .cas_timeslot_i(cas_timeslot_i),
    .cas_data_i(cas_data_i), .frame_valid_i(frame_valid_i),
    .frame_is_align_i(frame_is_align_i), .ts0_byte_i(ts0_byte_i),
    .irq_o(irq_o));

  framer_feed_model i_feed (
    .clk_i(clk_i), .cas_valid_o(cas_valid_i), .cas_ts_o(cas_timeslot_i),
    .cas_data_o(cas_data_i), .frame_valid_o(frame_valid_i),
    .frame_align_o(frame_is_align_i), .ts0_byte_o(ts0_byte_i));

  // counts and verdict; the single exit of the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  // avalon cycle: hold everything until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [13:0] idx,
                     input logic [7:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h0000_0000;
    @(posedge clk_i);
    avs_address_i   <= {idx, 2'h0};
    avs_read_i      <= ~w;
    avs_write_i     <= w;
    avs_writedata_i <= {24'h00_0000, wd};
    // waitrequest and read data are judged at the rising edge itself
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 64);
    if (avs_waitrequest_o !== 1'b0) begin
      bad_count++;
      stop_test();
    end else begin
      q = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
    end
  endtask : bus

  task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, rd);
    `CHK(rd, {24'h00_0000, exp})
  endtask : rd_chk

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, rd);
  endtask : wr

  task automatic test_reset();
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS8, 8'h00);
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS16, 8'h00);
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS24, 8'h00);
    rd_chk(e1_rx_status_pkg::IDX_NATIONAL, 8'h00);
    rd_chk(e1_rx_status_pkg::IDX_SIG_SELECT, 8'h00);
    wr(14'h0200, 8'hFF);
    rd_chk(14'h0200, 8'h00);
    // a write without lane 0 must leave the select alone
    avs_byteenable_i <= 4'hE;
    wr(e1_rx_status_pkg::IDX_SIG_SELECT, 8'h03);
    avs_byteenable_i <= 4'hF;
    rd_chk(e1_rx_status_pkg::IDX_SIG_SELECT, 8'h00);
    `CHK(irq_o, 1'b0)
    $display("test reset done");
  endtask : test_reset

  // every select code; only the two cas codes let a change through
  task automatic test_select();
    logic [7:0] exp;
    for (int c = 0; c < 8; c++) begin
      wr(e1_rx_status_pkg::IDX_SIG_SELECT, 8'(c));
      i_feed.send_cas(5'h08, 4'(c + 1));
      exp = (c == 1 || c == 3) ? 8'h80 : 8'h00;
      rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS8, exp);
    end
    $display("test select done");
  endtask : test_select

  // bit order at timeslots 9 and 15 and at both ends of the upper two groups, then clear on read
  task automatic test_mapping();
    logic [4:0]  t[6] = '{5'h09, 5'h0F, 5'h10, 5'h17, 5'h18, 5'h1F};
    logic [13:0] g;
    logic [7:0]  b;
    wr(e1_rx_status_pkg::IDX_SIG_SELECT, 8'h03);
    i_feed.send_cas(5'h03, 4'h7);
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS8, 8'h00);
    foreach (t[i]) begin
      g = e1_rx_status_pkg::IDX_FLAGS_TS8 + 14'((t[i] - 5'h08) >> 3);
      b = 8'h80 >> ((t[i] - 5'h08) & 5'h07);
      i_feed.send_cas(t[i], 4'hA);
      wr(g, 8'hFF);
      rd_chk(g, b);
      rd_chk(g, 8'h00);
      i_feed.send_cas(t[i], 4'hA);
      rd_chk(g, 8'h00);
    end
    $display("test mapping done");
  endtask : test_mapping

  // a change with the request misses the snapshot and survives; a change
  // in the answer cycle meets the clear of its own bit and still wins
  task automatic test_read_race();
    fork
      bus(1'b0, e1_rx_status_pkg::IDX_FLAGS_TS16, 8'h00, rd);
      i_feed.send_cas(5'h14, 4'h3);
    join
    `CHK(rd, 32'h0000_0000)
    fork
      bus(1'b0, e1_rx_status_pkg::IDX_FLAGS_TS16, 8'h00, rd);
      begin
        @(posedge clk_i);
        i_feed.send_cas(5'h14, 4'h5);
      end
    join
    `CHK(rd, 32'h0000_0008)
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS16, 8'h08);
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS16, 8'h00);
    $display("test read race done");
  endtask : test_read_race

  task automatic test_capture();
    // si is the first bit (msb); the fixed bit below it is dropped
    i_feed.send_frame(1'b0, 8'hBF);
    rd_chk(e1_rx_status_pkg::IDX_NATIONAL, 8'h7F);
    i_feed.send_frame(1'b1, 8'h80);
    rd_chk(e1_rx_status_pkg::IDX_NATIONAL, 8'hFF);
    i_feed.send_frame(1'b0, 8'h61);
    rd_chk(e1_rx_status_pkg::IDX_NATIONAL, 8'hA1);
    i_feed.send_frame(1'b1, 8'h7F);
    wr(e1_rx_status_pkg::IDX_NATIONAL, 8'hFF);
    rd_chk(e1_rx_status_pkg::IDX_NATIONAL, 8'h21);
    $display("test capture done");
  endtask : test_capture

  task automatic test_irq();
    wr(e1_rx_status_pkg::IDX_IRQ_MASK, 8'h00);
    wr(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h03);
    rd_chk(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h00);
    i_feed.send_cas(5'h0A, 4'h5);
    i_feed.send_frame(1'b0, 8'h01);
    rd_chk(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h03);
    `CHK(irq_o, 1'b0)
    wr(e1_rx_status_pkg::IDX_IRQ_MASK, 8'h01);
    rd_chk(e1_rx_status_pkg::IDX_IRQ_MASK, 8'h01);
    `CHK(irq_o, 1'b1)
    wr(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h01);
    rd_chk(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h02);
    `CHK(irq_o, 1'b0)
    // the write lands at the answer edge; look one edge later
    wr(e1_rx_status_pkg::IDX_IRQ_MASK, 8'h02);
    @(posedge clk_i);
    `CHK(irq_o, 1'b1)
    wr(e1_rx_status_pkg::IDX_IRQ_STATUS, 8'h02);
    @(posedge clk_i);
    `CHK(irq_o, 1'b0)
    rd_chk(e1_rx_status_pkg::IDX_FLAGS_TS8, 8'h20);
    $display("test irq done");
  endtask : test_irq

  // hang guard at 100000 cycles, far above the length of the whole run
  initial begin
    repeat (100000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    test_reset();
    test_select();
    test_mapping();
    test_read_race();
    test_capture();
    test_irq();
    stop_test();
  end
endmodule : e1_rx_cas_change_and_national_bits_test
`undef CHK
`default_nettype wire
